// File: src/usart_pkg.sv
// Shared constants and types for the asynchronous serial transmitter and its link partner
package usart_pkg;
   // Register offsets
   localparam logic [7:0] OFS_RX_CTRL     = 8'h18;
   localparam logic [7:0] OFS_TX_BUF      = 8'h19;
   localparam logic [7:0] OFS_RX_BUF      = 8'h1A;
   localparam logic [7:0] OFS_TX_CTRL     = 8'h98;
   localparam logic [7:0] OFS_DIVISOR     = 8'h99;
   localparam logic [7:0] OFS_FLAGS       = 8'h0C;
   localparam logic [7:0] OFS_IRQ_EN      = 8'h8C;
   // Reset values
   localparam logic [7:0] RST_RX_CTRL     = 8'h00;
   localparam logic [7:0] RST_TX_CTRL     = 8'h02;
   localparam logic [7:0] RST_DIVISOR     = 8'h00;
   // Transmit control bit positions
   localparam int TXC_NINE      = 6;
   localparam int TXC_EN        = 5;
   localparam int TXC_MODE      = 4;
   localparam int TXC_HIGHSPEED = 2;
   localparam int TXC_SHIFT_MT  = 1;
   localparam int TXC_NINTH     = 0;
   localparam logic [7:0] TXC_WR_MASK = 8'hF5;
   // Receive control bit positions
   localparam int RXC_PORT_EN   = 7;
   localparam int RXC_RX_NINE   = 6;
   localparam int RXC_CONT_EN   = 4;
   localparam int RXC_NINTH     = 0;
   // Flag / enable bit position
   localparam int FLG_TX_EMPTY  = 4;
   localparam int FLG_RX_FULL   = 5;
   // Baud prescales: ticks of the divider per bit, less one
   localparam logic [5:0] PRE_ASYNC_LOW  = 6'd63;
   localparam logic [5:0] PRE_ASYNC_HIGH = 6'd15;
   localparam logic [5:0] PRE_SYNC       = 6'd3;
   // Majority sample points within a 16-phase bit, last phase and stop indices
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] PHASE_LAST = 4'hF;
   localparam logic [3:0] STOP_INDEX_8 = 4'h9;
   localparam logic [3:0] STOP_INDEX_9 = 4'hA;
   // Register bus data width
   localparam int DW = 8;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_START = 2'b01,
      TX_DATA  = 2'b10,
      TX_STOP  = 2'b11
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;

   // Majority of three samples
   function automatic logic majority3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction
endpackage

// File: src/serial_link_if.sv
// Serial link between the transmitting device and the remote receiver
`timescale 1ns/1ps
interface serial_link_if;
   logic line_o;
   logic line_oe;
   logic line;
   assign line = line_oe ? line_o : 1'b1;
   modport device (output line_o, output line_oe, input line);
   modport remote (input line);
endinterface

// File: src/uart_baud_gen_async_tx.sv
// Baud generator, asynchronous transmitter and receive-pin majority sampler
//
// Summary of operation
// - Free-running 8-bit timer, divisor sets period
// - Rates divide by 64, 16 or 4
// - Clocked mode ignores high-speed select
// - Divisor write clears the baud timer
// - Receive pin majority of three samples
// - Frame: start, eight or nine, stop
// - Data bits least significant first
// - Transmit and receive share format, rate
// - No hardware parity; ninth bit by software
// - Sleep halts asynchronous operation
// - Mode bit clear selects asynchronous
// - Shifter reloads after stop, if buffered
// - Empty flag cleared only by buffer write
// - Interrupt enable gates empty flag request
// - Shifter-empty status, polled, no interrupt
// - Transmit enable sets empty flag if buffer empty
// - Start needs enable, data, shift clock
// - Empty shifter takes buffer write directly
// - Clearing enable aborts, pin floats
// - Nine-bit select; ninth bit written first
// - Software may prefer high-speed for accuracy
// - Software clears mode, sets port enable
`timescale 1ns/1ps
module uart_baud_gen_async_tx
   import usart_pkg::*;
(
   // Clock, reset, enable
   input  wire logic          mclk,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic          sleep,
   // Register port
   input  wire logic [7:0]    addr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic          wr,
   input  wire logic          rd,
   output logic      [DW-1:0] rdata,
   // Status outputs
   output logic               irq,
   output logic               rx_bit_valid,
   output logic               rx_bit,
   // Serial pins
   input  wire logic          receive_pin,
   serial_link_if.device      link
);
   typedef struct packed {
      logic [7:0]  tx_ctrl;
      logic [7:0]  rx_ctrl;
      logic [7:0]  divisor;
      logic [7:0]  irq_en;
      logic [7:0]  baud_cnt;
      logic [5:0]  pre_cnt;
      logic [7:0]  tx_buf;
      logic        tx_buf_full;
      logic        tx_empty_flag;
      logic [8:0]  shifter;
      logic [3:0]  bit_idx;
      tx_state_t   tx_state;
      logic        line_o;
      logic        line_oe;
      logic [3:0]  rx_phase;
      logic [2:0]  samples;
      logic [1:0]  rx_sync;
      logic        rx_bit_valid;
      logic        rx_bit;
      logic [DW-1:0] rdata;
      logic        irq;
   } state_t;

   state_t s_r, s_nxt;
   logic   async_run;
   logic   bit_tick;
   logic   sub_tick;
   logic   en_now;
   logic   load_shift;
   logic [5:0] pre_max;

   always_comb begin
      s_nxt      = s_r;
      async_run  = s_r.rx_ctrl[RXC_PORT_EN] && !s_r.tx_ctrl[TXC_MODE] && !sleep;
      if (s_r.tx_ctrl[TXC_MODE])
         pre_max = PRE_SYNC;
      else if (s_r.tx_ctrl[TXC_HIGHSPEED])
         pre_max = PRE_ASYNC_HIGH;
      else
         pre_max = PRE_ASYNC_LOW;
      sub_tick   = 1'b0;
      bit_tick   = 1'b0;
      s_nxt.rdata        = '0;
      s_nxt.rx_bit_valid = 1'b0;

      // Baud timer: one sub-tick per divisor+1 cycles; bit tick per pre_max+1 sub-ticks
      if (!sleep) begin
         if (s_r.baud_cnt == s_r.divisor) begin
            s_nxt.baud_cnt = '0;
            sub_tick       = 1'b1;
         end else begin
            s_nxt.baud_cnt = s_r.baud_cnt + 8'h01;
         end
         if (sub_tick) begin
            if (s_r.pre_cnt >= pre_max) begin
               s_nxt.pre_cnt = '0;
               bit_tick      = 1'b1;
            end else begin
               s_nxt.pre_cnt = s_r.pre_cnt + 6'd1;
            end
         end
      end

      // Receive pin majority sampler, shared bit clock, 16 phases per bit
      s_nxt.rx_sync = {s_r.rx_sync[0], receive_pin};
      if (async_run && sub_tick && (s_r.pre_cnt[1:0] == 2'b00 || s_r.tx_ctrl[TXC_HIGHSPEED])) begin
         s_nxt.rx_phase = s_r.rx_phase + 4'h1;
         if (s_r.rx_phase == SAMPLE_A || s_r.rx_phase == SAMPLE_B || s_r.rx_phase == SAMPLE_C)
            s_nxt.samples = {s_r.samples[1:0], s_r.rx_sync[1]};
         if (s_r.rx_phase == SAMPLE_C) begin
            s_nxt.rx_bit       = majority3({s_r.samples[1:0], s_r.rx_sync[1]});
            s_nxt.rx_bit_valid = 1'b1;
         end
      end

      // Transmit state machine
      en_now     = s_r.tx_ctrl[TXC_EN];
      load_shift = 1'b0;
      if (!en_now) begin
         s_nxt.tx_state = TX_IDLE;
         s_nxt.line_oe  = 1'b0;
         s_nxt.line_o   = 1'b1;
      end else if (async_run) begin
         s_nxt.line_oe = 1'b1;
         unique case (s_r.tx_state)
            TX_IDLE: begin
               s_nxt.line_o = 1'b1;
               if (s_r.tx_buf_full) begin
                  load_shift     = 1'b1;
                  s_nxt.shifter  = {s_r.tx_ctrl[TXC_NINTH], s_r.tx_buf};
                  s_nxt.tx_state = TX_START;
               end
            end
            TX_START: begin
               if (bit_tick) begin
                  s_nxt.line_o   = 1'b0;
                  s_nxt.bit_idx  = 4'h0;
                  s_nxt.tx_state = TX_DATA;
               end
            end
            TX_DATA: begin
               if (bit_tick) begin
                  s_nxt.bit_idx = s_r.bit_idx + 4'h1;
                  if ((s_r.bit_idx == 4'h8 && !s_r.tx_ctrl[TXC_NINE]) || s_r.bit_idx == 4'h9) begin
                     s_nxt.line_o   = 1'b1;
                     s_nxt.tx_state = TX_STOP;
                  end else begin
                     s_nxt.line_o  = s_r.shifter[0];
                     s_nxt.shifter = {1'b0, s_r.shifter[8:1]};
                  end
               end
            end
            TX_STOP: begin
               if (bit_tick) begin
                  if (s_r.tx_buf_full) begin
                     load_shift     = 1'b1;
                     s_nxt.shifter  = {s_r.tx_ctrl[TXC_NINTH], s_r.tx_buf};
                     s_nxt.tx_state = TX_START;
                  end else begin
                     s_nxt.tx_state = TX_IDLE;
                  end
               end
            end
         endcase
      end

      if (load_shift) begin
         s_nxt.tx_buf_full   = 1'b0;
         s_nxt.tx_empty_flag = 1'b1;
      end

      // Register writes
      if (wr) begin
         unique case (addr)
            OFS_TX_CTRL: begin
               s_nxt.tx_ctrl = (wdata & TXC_WR_MASK) | (s_r.tx_ctrl & ~TXC_WR_MASK);
               if (wdata[TXC_EN] && !s_r.tx_ctrl[TXC_EN])
                  s_nxt.tx_empty_flag = !s_r.tx_buf_full || load_shift;
            end
            OFS_RX_CTRL: s_nxt.rx_ctrl = {wdata[7:4], 4'h0};
            OFS_DIVISOR: begin
               s_nxt.divisor = wdata;
               s_nxt.baud_cnt = '0;
               s_nxt.pre_cnt = '0;
            end
            OFS_IRQ_EN:  s_nxt.irq_en = wdata;
            OFS_TX_BUF: begin
               s_nxt.tx_buf        = wdata;
               s_nxt.tx_buf_full   = 1'b1;
               s_nxt.tx_empty_flag = 1'b0;
            end
            default: ;
         endcase
      end

      s_nxt.tx_ctrl[TXC_SHIFT_MT] = (s_nxt.tx_state == TX_IDLE);
      s_nxt.irq = s_nxt.tx_empty_flag && s_nxt.irq_en[FLG_TX_EMPTY];

      if (rd) begin
         unique case (addr)
            OFS_TX_CTRL: s_nxt.rdata = s_r.tx_ctrl;
            OFS_RX_CTRL: s_nxt.rdata = s_r.rx_ctrl;
            OFS_DIVISOR: s_nxt.rdata = s_r.divisor;
            OFS_IRQ_EN:  s_nxt.rdata = s_r.irq_en;
            OFS_TX_BUF:  s_nxt.rdata = s_r.tx_buf;
            OFS_FLAGS:   s_nxt.rdata = {3'b000, s_r.tx_empty_flag, 4'h0};
            default:     s_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r         <= '0;
         s_r.tx_ctrl <= RST_TX_CTRL;
         s_r.rx_ctrl <= RST_RX_CTRL;
         s_r.divisor <= RST_DIVISOR;
         s_r.line_o  <= 1'b1;
         s_r.rx_sync <= 2'b11;
         s_r.samples <= 3'b111;
         s_r.rx_bit  <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign rdata        = s_r.rdata;
   assign irq          = s_r.irq;
   assign rx_bit_valid = s_r.rx_bit_valid;
   assign rx_bit       = s_r.rx_bit;
   assign link.line_o  = s_r.line_o;
   assign link.line_oe = s_r.line_oe;
endmodule

// File: src/uart_remote_rx.sv
// Remote asynchronous receiver on the transmit line
`timescale 1ns/1ps
module uart_remote_rx
   import usart_pkg::*;
#(
   parameter int unsigned CYCLES_PER_BIT = 16
)(
   // Clock, reset, enable
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic ce,
   // Configuration
   input  wire logic nine_bit,
   // Received data
   output logic [8:0] data,
   output logic       data_valid,
   output logic       frame_err,
   // Serial line
   serial_link_if.remote link
);
   typedef struct packed {
      logic [1:0]  sync;
      rx_state_t   st;
      logic [15:0] cnt;
      logic [3:0]  idx;
      logic [8:0]  sh;
      logic [8:0]  data;
      logic        valid;
      logic        ferr;
   } state_t;

   localparam logic [15:0] HALF = 16'((CYCLES_PER_BIT - 1) / 2);
   localparam logic [15:0] FULL = 16'(CYCLES_PER_BIT - 1);

   state_t s_r, s_nxt;
   logic   ln;

   always_comb begin
      s_nxt       = s_r;
      s_nxt.sync  = {s_r.sync[0], link.line};
      s_nxt.valid = 1'b0;
      ln          = s_r.sync[1];
      unique case (s_r.st)
         RX_IDLE: if (!ln) begin
            s_nxt.st  = RX_START;
            s_nxt.cnt = '0;
         end
         RX_START: begin
            s_nxt.cnt = s_r.cnt + 16'd1;
            if (s_r.cnt == HALF) begin
               s_nxt.cnt = '0;
               s_nxt.idx = '0;
               s_nxt.st  = ln ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            s_nxt.cnt = s_r.cnt + 16'd1;
            if (s_r.cnt == FULL) begin
               s_nxt.cnt = '0;
               s_nxt.sh  = {ln, s_r.sh[8:1]};
               s_nxt.idx = s_r.idx + 4'h1;
               if ((s_r.idx == 4'h7 && !nine_bit) || s_r.idx == 4'h8)
                  s_nxt.st = RX_STOP;
            end
         end
         RX_STOP: begin
            s_nxt.cnt = s_r.cnt + 16'd1;
            if (s_r.cnt == FULL) begin
               s_nxt.data  = nine_bit ? s_r.sh : {1'b0, s_r.sh[8:1]};
               s_nxt.valid = 1'b1;
               s_nxt.ferr  = !ln;
               s_nxt.st    = RX_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r      <= '0;
         s_r.sync <= 2'b11;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign data       = s_r.data;
   assign data_valid = s_r.valid;
   assign frame_err  = s_r.ferr;
endmodule

// File: verif/serial_link_properties.sv
// Assertions on the serial line between transmitter and remote receiver
`timescale 1ns/1ps
module serial_link_properties
#(
   parameter int BIT     = 16,
   parameter int MAX_LOW = 640
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link and power state
   input wire logic line_o,
   input wire logic line_oe,
   input wire logic sleep
);
   logic [15:0] lo_r;
   logic [15:0] hi_r;
   logic        hi_ok_r;

   // Run lengths of low and high levels while the line is driven
   always_ff @(posedge mclk) begin
      if (rst || !line_oe) begin
         lo_r    <= 16'h0000;
         hi_r    <= 16'h0000;
         hi_ok_r <= 1'b0;
      end else begin
         lo_r    <= line_o ? 16'h0000 : lo_r + 16'h0001;
         hi_r    <= line_o ? hi_r + 16'h0001 : 16'h0000;
         hi_ok_r <= hi_ok_r | (line_o & (lo_r != 16'h0000));
      end
   end

   reset_release_a: assert property (@(posedge mclk) rst |=> !line_oe && line_o)
      else $error("line driven after reset");
   idle_high_a: assert property (@(posedge mclk) disable iff (rst) $rose(line_oe) |-> line_o)
      else $error("line not idle high when enabled");
   low_run_a: assert property (@(posedge mclk) disable iff (rst)
      line_oe && $past(line_oe) && $rose(line_o) |-> lo_r != 16'h0000 && lo_r % BIT == 0)
      else $error("low run not whole bit periods");
   high_run_a: assert property (@(posedge mclk) disable iff (rst)
      line_oe && $past(line_oe) && $fell(line_o) && hi_ok_r |-> hi_r >= BIT && hi_r % BIT == 0)
      else $error("start not on a bit tick");
   low_max_a: assert property (@(posedge mclk) disable iff (rst) line_oe && !line_o |-> lo_r < MAX_LOW)
      else $error("line low longer than a frame");
   start_bit_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(line_o) && line_oe |-> (!line_o || !line_oe)[*8])
      else $error("start bit too short");
   stop_high_a: assert property (@(posedge mclk) disable iff (rst)
      line_oe && $past(line_oe) && $rose(line_o) |-> (line_o || !line_oe)[*8])
      else $error("high bit too short");
   sleep_hold_a: assert property (@(posedge mclk) disable iff (rst)
      sleep && $past(sleep) && $past(sleep, 2) |-> $stable(line_o) && $stable(line_oe))
      else $error("line moved during sleep");

   cover property (@(posedge mclk) $fell(line_o) && line_oe);
   cover property (@(posedge mclk) $fell(line_oe) && !$past(line_o));
   cover property (@(posedge mclk) lo_r == 16'h0090);
   cover property (@(posedge mclk) sleep && line_oe);
endmodule

// File: verif/testbench.sv
// Register-level tests of the transmitter against the remote receiver
`timescale 1ns/1ps
module testbench
   import usart_pkg::*;
;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       sleep = 1'b0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       nine = 1'b0;
   logic       receive_pin = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       irq, rx_bit_valid, rx_bit, rm_valid, rm_err, saved;
   logic [8:0] rm_data;
   int         errors = 0;
   int         n_tests = 0;
   int         cyc = 0;
   int         lows, v;

   serial_link_if lk ();
   always #2 mclk = ~mclk;

   uart_baud_gen_async_tx uart_baud_gen_async_tx_inst (.mclk(mclk), .rst(rst), .ce(1'b1), .sleep(sleep),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .rx_bit_valid(rx_bit_valid),
      .rx_bit(rx_bit), .receive_pin(receive_pin), .link(lk.device));
   uart_remote_rx #(.CYCLES_PER_BIT(16)) uart_remote_rx_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
      .nine_bit(nine), .data(rm_data), .data_valid(rm_valid), .frame_err(rm_err), .link(lk.remote));
   serial_link_properties #(.BIT(16), .MAX_LOW(640)) serial_link_properties_inst (.mclk(mclk), .rst(rst),
      .line_o(lk.line_o), .line_oe(lk.line_oe), .sleep(sleep));

   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 check("rdata", 11'(rdata), 11'(e));
   endtask

   task automatic wait_low();
      int i = 0;
      while (lk.line !== 1'b0 && i < 4000) begin
         @(posedge mclk);
         #1 i++;
      end
   endtask

   // Samples each bit cell in its middle, then awaits the remote's result if use_rm is set
   task automatic recv(input logic [8:0] d, input int nb, input int per, input bit use_rm);
      logic [10:0] w;
      int          i;
      w = 11'h000;
      wait_low();
      repeat (per / 2) @(posedge mclk);
      for (i = 0; i < nb + 2; i++) begin
         #1 w[i] = lk.line;
         if (i < nb + 1) repeat (per) @(posedge mclk);
      end
      check("frame", w, (11'h001 << (nb + 1)) | {1'b0, d, 1'b0});
      if (use_rm) begin
         i = 0;
         while (rm_valid !== 1'b1 && i < per + 8) begin
            @(posedge mclk);
            #1 i++;
         end
         check("remote", {rm_valid, rm_err, rm_data}, {2'b10, d});
      end
   endtask

   task automatic xfer(input logic [8:0] d, input int nb, input int per, input bit use_rm);
      fork
         recv(d, nb, per, use_rm);
         wr_reg(OFS_TX_BUF, d[7:0]);
      join
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end

   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(OFS_TX_CTRL, RST_TX_CTRL);
      rd_chk(OFS_RX_CTRL, RST_RX_CTRL);
      rd_chk(OFS_DIVISOR, RST_DIVISOR);
      rd_chk(8'h55, 8'h00);
      $display("test reset_values done");
      wr_reg(OFS_RX_CTRL, 8'h80);
      wr_reg(OFS_IRQ_EN, 8'h10);
      wr_reg(OFS_TX_CTRL, 8'h04);
      rd_chk(OFS_FLAGS, 8'h00);
      wr_reg(OFS_TX_CTRL, 8'h24);
      rd_chk(OFS_FLAGS, 8'h10);
      check("irq", 11'(irq), 11'h001);
      wr_reg(OFS_FLAGS, 8'h00);
      rd_chk(OFS_FLAGS, 8'h10);
      wr_reg(OFS_IRQ_EN, 8'h00);
      @(posedge mclk);
      #1 check("irq", 11'(irq), 11'h000);
      rd_chk(OFS_TX_CTRL, 8'h26);
      $display("test flags done");
      fork
         begin
            recv(9'h0A5, 8, 16, 1'b1);
            recv(9'h001, 8, 16, 1'b1);
         end
         begin
            wr_reg(OFS_TX_BUF, 8'hA5);
            wr_reg(OFS_TX_BUF, 8'h01);
            rd_chk(OFS_FLAGS, 8'h00);
            rd_chk(OFS_TX_CTRL, 8'h24);
         end
      join
      rd_chk(OFS_FLAGS, 8'h10);
      $display("test back_to_back done");
      wr_reg(OFS_TX_CTRL, 8'h65);
      nine <= 1'b1;
      xfer(9'h1A5, 9, 16, 1'b1);
      wr_reg(OFS_TX_CTRL, 8'h64);
      xfer(9'h000, 9, 16, 1'b1);
      nine <= 1'b0;
      $display("test nine_bit done");
      wr_reg(OFS_TX_CTRL, 8'h34);
      wr_reg(OFS_TX_BUF, 8'h5A);
      lows = 0;
      repeat (100) begin
         @(posedge mclk);
         #1 lows += (lk.line === 1'b0);
      end
      check("idle", 11'(lows), 11'h000);
      // Clear enable and mode bit; the held byte goes out in asynchronous mode once re-enabled
      wr_reg(OFS_TX_CTRL, 8'h04);
      rd_chk(OFS_FLAGS, 8'h00);
      fork
         recv(9'h05A, 8, 16, 1'b1);
         wr_reg(OFS_TX_CTRL, 8'h24);
      join
      $display("test mode done");
      wr_reg(OFS_TX_BUF, 8'h00);
      wait_low();
      repeat (20) @(posedge mclk);
      wr_reg(OFS_TX_CTRL, 8'h04);
      @(posedge mclk);
      #1 check("float", {9'h000, lk.line_oe, lk.line}, 11'h001);
      rd_chk(OFS_TX_CTRL, 8'h06);
      $display("test abort done");
      wr_reg(OFS_TX_CTRL, 8'h24);
      wr_reg(OFS_TX_BUF, 8'h0F);
      wait_low();
      // Sleep in a high bit whose level differs from the bit seen without sleep
      repeat (72) @(posedge mclk);
      sleep <= 1'b1;
      #1 saved = lk.line;
      repeat (32) @(posedge mclk);
      sleep <= 1'b0;
      #1 check("sleep", 11'(lk.line), 11'(saved));
      repeat (300) @(posedge mclk);
      $display("test sleep done");
      wr_reg(OFS_TX_CTRL, 8'h04);
      wr_reg(OFS_DIVISOR, 8'h01);
      wr_reg(OFS_TX_CTRL, 8'h24);
      xfer(9'h096, 8, 32, 1'b0);
      wr_reg(OFS_TX_CTRL, 8'h00);
      wr_reg(OFS_DIVISOR, 8'h00);
      wr_reg(OFS_TX_CTRL, 8'h20);
      xfer(9'h069, 8, 64, 1'b0);
      $display("test rates done");
      for (v = 0; v < 2; v++) begin
         receive_pin <= v[0];
         repeat (40) @(posedge mclk);
         #1 lows = 0;
         while (rx_bit_valid !== 1'b1 && lows < 80) begin
            @(posedge mclk);
            #1 lows++;
         end
         check("rx_bit", 11'({rx_bit_valid, rx_bit}), 11'({1'b1, v[0]}));
      end
      $display("test receive_pin done");
      end_sim();
   end
endmodule
